// ==== include/fpeg_pkg.sv ====
// Package of constants and types for the flash program/erase guard
package fpeg_pkg;
  // Key codes, written in this order to unlock one operation
  localparam logic [7:0] FPEG_KEY_FIRST = 8'hA5;
  localparam logic [7:0] FPEG_KEY_SECOND = 8'hF1;
  // Erased byte value
  localparam logic [7:0] FPEG_ERASED = 8'hFF;
  // Page size in bytes and its address width
  localparam int FPEG_PAGE_BYTES = 1024;
  localparam int FPEG_PAGE_BITS = 10;
  // Highest address an 8-bit-address write may touch
  localparam logic [15:0] FPEG_SHORT_ADDR_MAX = 16'h00FF;
  // Clock rate and operation times
  localparam int FPEG_CLK_MHZ = 100;
  localparam int FPEG_WRITE_TIME_US = 20;
  localparam int FPEG_ERASE_TIME_US = 20;
  localparam int FPEG_WRITE_CYCLES = FPEG_WRITE_TIME_US * FPEG_CLK_MHZ;
  localparam int FPEG_ERASE_CYCLES = FPEG_ERASE_TIME_US * FPEG_CLK_MHZ;
  // Control register bit positions
  localparam int FPEG_CTL_WE_BIT = 0;
  localparam int FPEG_CTL_EE_BIT = 1;
  // Register select codes on the special register port
  localparam logic [1:0] FPEG_REG_CONTROL = 2'h0;
  localparam logic [1:0] FPEG_REG_KEY = 2'h1;
  localparam logic [1:0] FPEG_REG_BANK = 2'h2;
  // Key tracker states
  typedef enum logic [1:0] {
    FPEG_KEY_WAIT_FIRST = 2'b00,
    FPEG_KEY_WAIT_SECOND = 2'b01,
    FPEG_KEY_OPEN = 2'b10
  } fpeg_key_state_t;
  // Operation sequencer states
  typedef enum logic [1:0] {
    FPEG_OP_IDLE = 2'b00,
    FPEG_OP_WRITE = 2'b01,
    FPEG_OP_ERASE = 2'b10
  } fpeg_op_state_t;
endpackage

// ==== include/fpeg_if.sv ====
// Interface joining the CPU side and the flash guard
`timescale 1ns/1ps
`default_nettype none
interface fpeg_if;
  logic reg_wr;        // Special register write strobe
  logic [1:0] reg_sel; // Which register
  logic [7:0] reg_data;
  logic xw_valid;      // External-memory write instruction
  logic xw_short;      // Instruction used an 8-bit address
  logic [1:0] xw_bank;
  logic [15:0] xw_addr;
  logic [7:0] xw_data;
  logic stall;         // Execution held while flash busy
  logic [7:0] status;  // Guard state for software reads
  modport guard (input reg_wr, reg_sel, reg_data, xw_valid, xw_short, xw_bank, xw_addr,
    xw_data, output stall, status);
  modport cpu (output reg_wr, reg_sel, reg_data, xw_valid, xw_short, xw_bank, xw_addr,
    xw_data, input stall, status);
endinterface
`default_nettype wire

// ==== hdl/fpeg_guard.sv ====
// Device end: flash program/erase guard with key lock and timer
// How it works
// - Programming only clears bits, ANDs data
// - Operations timed internally, execution stalled
// - Write-enable steers writes to flash, sticky
// - Key codes A5 then F1, any gap
// - Wrong key order disables flash until reset
// - Operation without key disables flash too
// - Lock closes as every operation starts
// - Unarmed supply monitor forces flash error reset
// - Erase sets whole 1024-byte page FF
// - Erase-enable plus write-enable erases page
// - Write-enable alone programs one byte
// - Software sets bank before key, access
// - Short-address writes above 00FF blocked
// - Software disables interrupts around sequences
// - Erase needs both enables set
// - Flash error flag reads one after a flash error reset
`timescale 1ns/1ps
`default_nettype none
module fpeg_guard #(
  parameter int WRITE_CYCLES = fpeg_pkg::FPEG_WRITE_CYCLES, // Byte program time
  parameter int ERASE_CYCLES = fpeg_pkg::FPEG_ERASE_CYCLES  // Page erase time
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  fpeg_if.guard bus,
  input wire logic monitor_on_i,       // Supply monitor enabled
  input wire logic monitor_reset_en_i, // Supply monitor is a reset source
  input wire logic [7:0] flash_rdata_i, // Current byte at target address
  output logic flash_wr_o,             // One-cycle byte program pulse
  output logic flash_erase_o,          // One-cycle page erase pulse
  output logic [1:0] flash_bank_o,
  output logic [15:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  output logic ram_wr_o,               // Write goes to data RAM
  output logic flash_error_reset_o,    // One-cycle device reset request
  output logic flash_error_reset_flag_o // Sticky cause flag
);
  import fpeg_pkg::*;

  logic [7:0] program_store_control; // Write/erase enables
  logic [1:0] code_bank_select;      // Bank for flash access
  fpeg_key_state_t key_state;        // Key tracker
  logic flash_disabled;              // Sticky until system reset
  fpeg_op_state_t op_state;
  logic [31:0] op_count;             // Remaining busy cycles
  logic stall_q;
  logic we;
  logic ee;
  logic key_wr;
  logic flash_target;
  logic attempt;
  logic monitor_ok;
  logic addr_ok;
  logic go;

  assign we = program_store_control[FPEG_CTL_WE_BIT];
  assign ee = program_store_control[FPEG_CTL_EE_BIT];
  assign key_wr = bus.reg_wr && (bus.reg_sel == FPEG_REG_KEY);
  // Writes aim at flash only while write-enable is set
  assign flash_target = bus.xw_valid && we && !stall_q;
  assign monitor_ok = monitor_on_i && monitor_reset_en_i;
  // Short-form addresses cannot reach beyond the first 256 bytes
  assign addr_ok = !(bus.xw_short && (bus.xw_addr > FPEG_SHORT_ADDR_MAX));
  assign attempt = flash_target && monitor_ok && addr_ok;
  assign go = attempt && !flash_disabled && (key_state == FPEG_KEY_OPEN);
  assign bus.stall = stall_q;
  assign bus.status = {3'h0, flash_error_reset_flag_o, flash_disabled, stall_q,
    key_state == FPEG_KEY_OPEN, 1'b0};

  // Control and bank registers; bits stay until software changes them
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      program_store_control <= 8'h00;
      code_bank_select <= 2'h0;
    end else if (bus.reg_wr) begin
      if (bus.reg_sel == FPEG_REG_CONTROL) begin
        program_store_control <= bus.reg_data & 8'h03;
      end
      if (bus.reg_sel == FPEG_REG_BANK) begin
        code_bank_select <= bus.reg_data[1:0];
      end
    end
  end

  // Key tracker
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      key_state <= FPEG_KEY_WAIT_FIRST;
    end else if (go) begin
      key_state <= FPEG_KEY_WAIT_FIRST; // Relock per operation
    end else if (flash_disabled) begin
      key_state <= FPEG_KEY_WAIT_FIRST; // Disabled lock never reports open
    end else if (key_wr) begin
      unique case (key_state)
        FPEG_KEY_WAIT_FIRST: begin
          key_state <= (bus.reg_data == FPEG_KEY_FIRST) ? FPEG_KEY_WAIT_SECOND
                                                        : FPEG_KEY_WAIT_FIRST;
        end
        FPEG_KEY_WAIT_SECOND: begin
          key_state <= (bus.reg_data == FPEG_KEY_SECOND) ? FPEG_KEY_OPEN
                                                         : FPEG_KEY_WAIT_FIRST;
        end
        FPEG_KEY_OPEN: begin
          key_state <= FPEG_KEY_WAIT_FIRST; // Extra key write is out of order
        end
        default: key_state <= FPEG_KEY_WAIT_FIRST;
      endcase
    end
  end

  // Sticky disable, cleared only by reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flash_disabled <= 1'b0;
    end else begin
      if (key_wr && !((key_state == FPEG_KEY_WAIT_FIRST && bus.reg_data == FPEG_KEY_FIRST) ||
          (key_state == FPEG_KEY_WAIT_SECOND && bus.reg_data == FPEG_KEY_SECOND))) begin
        flash_disabled <= 1'b1;
      end
      if (attempt && key_state != FPEG_KEY_OPEN) begin
        flash_disabled <= 1'b1;
      end
    end
  end

  // Flash error reset request; the flag survives the reset it causes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flash_error_reset_o <= 1'b0;
    end else begin
      flash_error_reset_o <= flash_target && !monitor_ok;
    end
  end

  // Cause flag: set by the error, cleared by any other reset
  always_ff @(posedge ref_clk_i) begin
    if (flash_error_reset_o) begin
      flash_error_reset_flag_o <= 1'b1;
    end else if (rst_i) begin
      flash_error_reset_flag_o <= 1'b0;
    end
  end

  // Operation sequencer with internal timing and stall
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      op_state <= FPEG_OP_IDLE;
      op_count <= 32'h0;
      stall_q <= 1'b0;
      flash_wr_o <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_addr_o <= 16'h0000;
      flash_wdata_o <= 8'h00;
      flash_bank_o <= 2'h0;
    end else begin
      flash_wr_o <= 1'b0;
      flash_erase_o <= 1'b0;
      unique case (op_state)
        FPEG_OP_IDLE: begin
          if (go) begin
            stall_q <= 1'b1;
            flash_bank_o <= code_bank_select;
            if (ee) begin
              // Erase only with both enables
              op_state <= FPEG_OP_ERASE;
              op_count <= 32'(ERASE_CYCLES);
              flash_erase_o <= 1'b1;
              flash_addr_o <= {bus.xw_addr[15:FPEG_PAGE_BITS], FPEG_PAGE_BITS'(0)};
              flash_wdata_o <= FPEG_ERASED;
            end else begin
              // Single byte; program can only clear bits
              op_state <= FPEG_OP_WRITE;
              op_count <= 32'(WRITE_CYCLES);
              flash_wr_o <= 1'b1;
              flash_addr_o <= bus.xw_addr;
              flash_wdata_o <= bus.xw_data & flash_rdata_i;
            end
          end
        end
        FPEG_OP_WRITE, FPEG_OP_ERASE: begin
          if (op_count <= 32'h1) begin
            op_state <= FPEG_OP_IDLE;
            stall_q <= 1'b0;
          end else begin
            op_count <= op_count - 32'h1;
          end
        end
        default: op_state <= FPEG_OP_IDLE;
      endcase
    end
  end

  // Plain RAM writes while write-enable is clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ram_wr_o <= 1'b0;
    end else begin
      ram_wr_o <= bus.xw_valid && !we && !stall_q;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/fpeg_cpu_end.sv ====
// CPU end: turns user requests into register and external-memory writes
`timescale 1ns/1ps
`default_nettype none
module fpeg_cpu_end (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  fpeg_if.cpu bus,
  input wire logic reg_req_i,        // Register write request
  input wire logic [1:0] reg_sel_i,
  input wire logic [7:0] reg_data_i,
  input wire logic xw_req_i,         // External-memory write request
  input wire logic xw_short_i,
  input wire logic [15:0] xw_addr_i,
  input wire logic [7:0] xw_data_i,
  output logic busy_o,               // Guard stalling execution
  output logic [7:0] status_o
);
  import fpeg_pkg::*;

  logic [1:0] bank_shadow; // Bank last written, sent with each access

  // Requests are held off while the guard stalls execution
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus.reg_wr <= 1'b0;
      bus.reg_sel <= 2'h0;
      bus.reg_data <= 8'h00;
      bus.xw_valid <= 1'b0;
      bus.xw_short <= 1'b0;
      bus.xw_addr <= 16'h0000;
      bus.xw_data <= 8'h00;
    end else begin
      bus.reg_wr <= reg_req_i && !bus.stall;
      bus.reg_sel <= reg_sel_i;
      bus.reg_data <= reg_data_i;
      bus.xw_valid <= xw_req_i && !bus.stall && !reg_req_i;
      bus.xw_short <= xw_short_i;
      bus.xw_addr <= xw_addr_i;
      bus.xw_data <= xw_data_i;
    end
  end

  // Bank is set before the key and access
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bank_shadow <= 2'h0;
    end else if (bus.reg_wr && bus.reg_sel == FPEG_REG_BANK) begin
      // Follows the strobe the guard sees, so a dropped write cannot split the copies
      bank_shadow <= bus.reg_data[1:0];
    end
  end
  assign bus.xw_bank = bank_shadow;

  // Status mirrors
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      status_o <= 8'h00;
    end else begin
      busy_o <= bus.stall;
      status_o <= bus.status;
    end
  end
endmodule
`default_nettype wire

// ==== bench/fpeg_checker.sv ====
// Checker watching the link between the CPU end and the flash guard
`timescale 1ns/1ps
`default_nettype none
module fpeg_checker #(
  parameter int WRITE_CYCLES = 4,
  parameter int ERASE_CYCLES = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic monitor_on_i,
  input wire logic monitor_reset_en_i,
  input wire logic reg_wr,
  input wire logic [1:0] reg_sel,
  input wire logic [7:0] reg_data,
  input wire logic xw_valid,
  input wire logic xw_short,
  input wire logic [15:0] xw_addr,
  input wire logic stall,
  input wire logic [7:0] status
);
  import fpeg_pkg::*;
  logic we;
  logic ee;
  logic erase_run;
  logic armed;
  logic in_reach;
  logic go;
  int unsigned cnt;
  assign armed = monitor_on_i && monitor_reset_en_i;
  assign in_reach = !(xw_short && xw_addr > FPEG_SHORT_ADDR_MAX);
  assign go = xw_valid && !stall && we && status[1] && armed && in_reach;
  // Shadow of the control bits; the guard keeps its own copy
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      we <= 1'b0;
      ee <= 1'b0;
    end else if (reg_wr && reg_sel == FPEG_REG_CONTROL) begin
      we <= reg_data[FPEG_CTL_WE_BIT];
      ee <= reg_data[FPEG_CTL_EE_BIT];
    end
  end
  // Kind of the running operation and its stall length
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      erase_run <= 1'b0;
      cnt <= 0;
    end else begin
      if (go) erase_run <= ee;
      cnt <= stall ? cnt + 1 : 0;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_status_layout: assert property (status[7:5] == 3'h0 && !status[0]
    && status[2] == stall)
    else $error("status layout wrong");
  a_op_starts: assert property (go |=> stall && !status[1])
    else $error("accepted write did not stall or relock");
  a_op_length: assert property ($fell(stall) |->
    cnt == (erase_run ? ERASE_CYCLES : WRITE_CYCLES))
    else $error("stall length wrong");
  a_key_opens: assert property ($rose(status[1]) |->
    $past(reg_wr && reg_sel == FPEG_REG_KEY && reg_data == FPEG_KEY_SECOND))
    else $error("lock opened without second code");
  a_bad_key: assert property (reg_wr && reg_sel == FPEG_REG_KEY && (status[1] ||
    (reg_data != FPEG_KEY_FIRST && reg_data != FPEG_KEY_SECOND)) |=> status[3])
    else $error("bad key did not disable");
  a_disable_sticky: assert property (status[3] |=> status[3] && !status[1])
    else $error("disable flag dropped");
  a_no_key_op: assert property (xw_valid && !stall && we && !status[1]
    && armed && in_reach |=> status[3] && !stall)
    else $error("keyless write not refused");
  a_short_ignored: assert property (xw_valid && !stall && !in_reach |=> !stall)
    else $error("short write above limit ran");
  a_unarmed_no_op: assert property (xw_valid && !stall && we && !armed |=> !stall)
    else $error("write ran with monitor unarmed");
  c_erase: cover property (go && ee);
  c_disabled: cover property ($rose(status[3]));
  c_done: cover property ($fell(stall));
endmodule
`default_nettype wire

// ==== bench/test_flash_program_erase_guard.sv ====
// Testbench driving the CPU end against the flash guard
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_erase_guard;
  import fpeg_pkg::*;
  localparam int WCYC = 4; // Short times keep the run small
  localparam int ECYC = 6; // Differs from WCYC to tell erase from write
  logic ref_clk = 1'b0, rst_tb = 1'b1, mon_on = 1'b1, mon_rst = 1'b1;
  logic reg_req = 1'b0, xw_req = 1'b0, xw_short = 1'b0;
  logic [1:0] reg_sel = 2'h0;
  logic [7:0] reg_data = 8'h00, xw_data = 8'h00, status, fwdata;
  logic [15:0] xw_addr = 16'h0000, faddr;
  logic busy, fwr, fer, ram_wr, err_rst, err_flag;
  logic [1:0] fbank;
  logic [7:0] mem [0:4095]; // Banks 0 and 1 below 0x0800 only
  int n_fail = 0, n_compared = 0, n_ram = 0, n_busy = 0;
  wire rst = rst_tb | err_rst; // Error reset feeds back as a device reset
  fpeg_if bus();
  wire [7:0] rdata = mem[{bus.xw_bank[0], bus.xw_addr[10:0]}];
  always #5 ref_clk = ~ref_clk;
  fpeg_guard #(.WRITE_CYCLES(WCYC), .ERASE_CYCLES(ECYC)) u_fpeg_guard (.ref_clk_i(ref_clk),
    .rst_i(rst), .bus(bus), .monitor_on_i(mon_on), .monitor_reset_en_i(mon_rst),
    .flash_rdata_i(rdata), .flash_wr_o(fwr), .flash_erase_o(fer), .flash_bank_o(fbank),
    .flash_addr_o(faddr), .flash_wdata_o(fwdata), .ram_wr_o(ram_wr),
    .flash_error_reset_o(err_rst), .flash_error_reset_flag_o(err_flag));
  fpeg_cpu_end u_fpeg_cpu_end (.ref_clk_i(ref_clk), .rst_i(rst), .bus(bus),
    .reg_req_i(reg_req), .reg_sel_i(reg_sel), .reg_data_i(reg_data), .xw_req_i(xw_req),
    .xw_short_i(xw_short), .xw_addr_i(xw_addr), .xw_data_i(xw_data), .busy_o(busy),
    .status_o(status));
  fpeg_checker #(.WRITE_CYCLES(WCYC), .ERASE_CYCLES(ECYC)) u_fpeg_checker (.ref_clk_i(ref_clk),
    .rst_i(rst), .monitor_on_i(mon_on), .monitor_reset_en_i(mon_rst), .reg_wr(bus.reg_wr),
    .reg_sel(bus.reg_sel), .reg_data(bus.reg_data), .xw_valid(bus.xw_valid),
    .xw_short(bus.xw_short), .xw_addr(bus.xw_addr), .stall(bus.stall), .status(bus.status));
  // Flash array model; an erase wipes the whole 1024-byte page
  always @(posedge ref_clk) begin
    if (fwr) mem[{fbank[0], faddr[10:0]}] <= fwdata;
    if (fer) for (int i = 0; i < FPEG_PAGE_BYTES; i++)
      mem[{fbank[0], faddr[10], 10'h000} + i] <= FPEG_ERASED;
    if (ram_wr) n_ram <= n_ram + 1;
  end
  task automatic end_of_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic do_reset;
    rst_tb = 1'b1;
    cyc(16);
    rst_tb = 1'b0;
    cyc(1);
  endtask
  task automatic reg_w(input logic [1:0] s, input logic [7:0] d);
    reg_sel = s;
    reg_data = d;
    reg_req = 1'b1;
    cyc(1);
    reg_req = 1'b0;
    cyc(1);
  endtask
  task automatic key;
    reg_w(FPEG_REG_KEY, FPEG_KEY_FIRST);
    reg_w(FPEG_REG_KEY, FPEG_KEY_SECOND);
  endtask
  // One write instruction; counts stalled cycles, gives up after a bound
  task automatic xw(input logic s, input logic [15:0] a, input logic [7:0] d);
    xw_short = s;
    xw_addr = a;
    xw_data = d;
    xw_req = 1'b1;
    cyc(1);
    xw_req = 1'b0;
    n_busy = 0;
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      if (busy === 1'b1) n_busy++;
      else if (n_busy > 0 || i > 6) return;
    end
    n_fail++;
    $display("[FAIL] %0t stall never ended", $time);
    end_of_test();
  endtask
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = FPEG_ERASED;
    mem[12'h500] = 8'h34;
    mem[12'hD00] = 8'h12;
    do_reset();
    chk(status, 8'h00);
    reg_w(FPEG_REG_CONTROL, 8'h01);
    key();
    cyc(1); // Status mirror lags the guard by one cycle
    chk(status, 8'h02);
    xw(1'b0, 16'h0010, 8'hF0);
    chk(mem[12'h010], 8'hF0);
    chk(8'(n_busy), 8'(WCYC));
    chk(status, 8'h00);
    key();
    xw(1'b0, 16'h0010, 8'h0F);
    chk(mem[12'h010], 8'h00);
    reg_w(FPEG_REG_CONTROL, 8'h03);
    reg_w(FPEG_REG_BANK, 8'h01);
    key();
    xw(1'b0, 16'h0413, 8'h55);
    chk(mem[12'hD00], FPEG_ERASED);
    chk(mem[12'h500], 8'h34);
    chk(8'(n_busy), 8'(ECYC));
    reg_w(FPEG_REG_CONTROL, 8'h00);
    reg_w(FPEG_REG_BANK, 8'h00);
    xw(1'b0, 16'h0020, 8'h00);
    chk(8'(n_ram), 8'h01);
    chk(mem[12'h020], FPEG_ERASED);
    reg_w(FPEG_REG_CONTROL, 8'h01);
    key();
    xw(1'b1, 16'h0123, 8'h00);
    chk(mem[12'h123], FPEG_ERASED);
    reg_w(FPEG_REG_KEY, FPEG_KEY_SECOND);
    cyc(1); // Status mirror lags the guard by one cycle
    chk(status, 8'h08);
    key();
    xw(1'b0, 16'h0030, 8'h00);
    chk(mem[12'h030], FPEG_ERASED);
    do_reset();
    reg_w(FPEG_REG_CONTROL, 8'h01);
    xw(1'b0, 16'h0040, 8'h00);
    chk(status, 8'h08);
    chk(mem[12'h040], FPEG_ERASED);
    do_reset();
    reg_w(FPEG_REG_CONTROL, 8'h01);
    key();
    mon_rst = 1'b0;
    xw(1'b0, 16'h0050, 8'h00);
    chk(mem[12'h050], FPEG_ERASED);
    chk(status, 8'h10);
    chk({7'h00, err_flag}, 8'h01);
    do_reset();
    chk({7'h00, err_flag}, 8'h00);
    reg_w(FPEG_REG_CONTROL, 8'h01);
    key();
    mon_on = 1'b0;
    mon_rst = 1'b1;
    xw(1'b0, 16'h0060, 8'h00);
    chk(mem[12'h060], FPEG_ERASED);
    chk({7'h00, err_flag}, 8'h01);
    end_of_test();
  end
endmodule
`default_nettype wire
